// file: rtl/pmta_pkg.sv
// Package of constants and types for the program memory table access unit
`default_nettype none
package pmta_pkg;
    localparam int          WORD_W      = 16;
    localparam int          BYTE_W      = 8;
    localparam logic [15:0] PTR_RESET   = 16'h0000;
    localparam logic [15:0] LATCH_RESET = 16'h0000;
    localparam logic [15:0] PTR_STEP    = 16'h0001;
    // Short write and external write last two instruction cycles
    localparam int          SHORT_WR_CYCLES = 2;
    // Timer-zero and pin sources, index 0 has highest priority
    localparam int          NUM_CORE_SRC = 3;

    typedef enum logic [2:0] {
        PMTA_OP_NONE,
        PMTA_OP_LATCH_WR,
        PMTA_OP_LATCH_RD,
        PMTA_OP_TABLE_WR,
        PMTA_OP_TABLE_RD
    } pmta_op_t;

    // Next pointer value, wraps modulo 65536
    function automatic logic [15:0] pmta_bump(input logic [15:0] p, input logic inc);
        pmta_bump = inc ? p + PTR_STEP : p;
    endfunction
endpackage
`default_nettype wire

// file: rtl/pmta_prio_pick.sv
// Priority picker for the core interrupt sources that clear on termination
`timescale 1ns/1ns
`default_nettype none
module pmta_prio_pick
    import pmta_pkg::*;
#(
    parameter int N = NUM_CORE_SRC
) (
    input  wire logic [N-1:0] req,
    output logic      [N-1:0] grant
);
    // Lowest index wins
    always_comb begin
        grant = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (req[k]) begin
                grant = '0;
                grant[k] = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/pmta_table_access.sv
// Table read and write unit between program memory and data space
// How it works
// - word moves as two byte operations via latch
// - latch write loads chosen latch byte only
// - table write stores latch at pointer address
// - increment operand one bumps pointer after access
// - external memory only in external modes
// - internal table write halts execution (long write)
// - only enabled flagged interrupt or reset ends
// - disable bit decides vectoring only
// - core sources get top flag auto-cleared
// - pending interrupt aborts internal table write as nop
// - peripheral flags never auto-cleared
// - no programming voltage gives a 2-cycle internal write that stores nothing (no write strobe)
// - external writes take exactly two cycles
// - read returns old byte then reloads latch
// - separate read and write latches
`timescale 1ns/1ns
`default_nettype none
module pmta_table_access
    import pmta_pkg::*;
#(
    parameter int NSRC = NUM_CORE_SRC,
    parameter int NPER = 4
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire pmta_op_t          opCode,
    input  wire logic              opHigh,
    input  wire logic              opIncrement,
    input  wire logic [7:0]        opData,
    input  wire logic              ptrLoadHigh,
    input  wire logic              ptrLoadLow,
    input  wire logic [7:0]        ptrLoadData,
    input  wire logic              externalMode,
    input  wire logic              programVoltageOk,
    input  wire logic              globalInterruptDisable,
    input  wire logic [NSRC-1:0]   coreIntEnable,
    input  wire logic [NSRC-1:0]   coreIntFlag,
    input  wire logic [NPER-1:0]   periphIntEnable,
    input  wire logic [NPER-1:0]   periphIntFlag,
    input  wire logic [15:0]       memReadData,
    output logic [7:0]             readByte,
    output logic                   readByteValid,
    output logic                   busy,
    output logic                   halted,
    output logic [15:0]            memAddr,
    output logic [15:0]            memWriteData,
    output logic                   memWriteInternal,
    output logic                   memWriteExternal,
    output logic                   memReadExternal,
    output logic                   vectorRequest,
    output logic [NSRC-1:0]        coreFlagClear,
    output logic [15:0]            tablePointer
);
    typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_LONG} pmta_state_t;

    pmta_state_t state, next_state;
    logic [15:0] writeLatch, next_writeLatch;
    logic [15:0] readLatch, next_readLatch;
    logic [15:0] next_tablePointer;
    logic [7:0]  next_readByte;
    logic        next_readByteValid;
    logic        pendInc, next_pendInc;
    logic        pendRead, next_pendRead;
    logic        pendExt, next_pendExt;
    logic [15:0] next_memAddr, next_memWriteData;
    logic        next_memWriteInternal, next_memWriteExternal, next_memReadExternal;
    logic        next_vectorRequest;
    logic [NSRC-1:0] next_coreFlagClear;
    logic [NSRC-1:0] coreActive, coreTop;
    logic        anyActive;

    assign coreActive = coreIntEnable & coreIntFlag;
    assign anyActive = (|coreActive) | (|(periphIntEnable & periphIntFlag));
    assign busy = (state != ST_IDLE);
    assign halted = (state == ST_LONG);

    pmta_prio_pick #(.N(NSRC)) uPick (
        .req   (coreActive),
        .grant (coreTop)
    );

    // Next-state and datapath decisions
    always_comb begin
        next_state = state;
        next_writeLatch = writeLatch;
        next_readLatch = readLatch;
        next_tablePointer = tablePointer;
        next_readByte = readByte;
        next_readByteValid = 1'b0;
        next_pendInc = pendInc;
        next_pendRead = pendRead;
        next_pendExt = pendExt;
        next_memAddr = memAddr;
        next_memWriteData = memWriteData;
        next_memWriteInternal = 1'b0;
        next_memWriteExternal = 1'b0;
        next_memReadExternal = 1'b0;
        next_vectorRequest = 1'b0;
        next_coreFlagClear = '0;
        unique case (state)
            ST_IDLE: begin
                if (ptrLoadHigh) next_tablePointer[15:8] = ptrLoadData;
                if (ptrLoadLow) next_tablePointer[7:0] = ptrLoadData;
                unique case (opCode)
                    PMTA_OP_NONE: begin
                    end
                    // loads one byte of write latch
                    PMTA_OP_LATCH_WR: begin
                        if (opHigh) next_writeLatch[15:8] = opData;
                        else next_writeLatch[7:0] = opData;
                    end
                    PMTA_OP_LATCH_RD: begin
                        next_readByte = opHigh ? readLatch[15:8] : readLatch[7:0];
                        next_readByteValid = 1'b1;
                    end
                    PMTA_OP_TABLE_WR: begin
                        // table write also loads a byte
                        if (opHigh) next_writeLatch[15:8] = opData;
                        else next_writeLatch[7:0] = opData;
                        next_pendInc = opIncrement;
                        next_pendRead = 1'b0;
                        next_pendExt = externalMode;
                        next_memAddr = tablePointer;
                        // word from latch to pointer address
                        next_memWriteData = next_writeLatch;
                        if (!externalMode && anyActive) begin
                            // pending interrupt turns write into nop
                            next_coreFlagClear = coreTop;
                            next_pendInc = 1'b0;
                            next_state = ST_SECOND;
                        end else if (!externalMode && programVoltageOk) begin
                            next_state = ST_LONG;
                        end else begin
                            next_state = ST_SECOND;
                        end
                    end
                    PMTA_OP_TABLE_RD: begin
                        next_readByte = opHigh ? readLatch[15:8] : readLatch[7:0];
                        next_readByteValid = 1'b1;
                        next_pendInc = opIncrement;
                        next_pendRead = 1'b1;
                        next_pendExt = externalMode;
                        next_memAddr = tablePointer;
                        next_state = ST_SECOND;
                    end
                    default: begin
                    end
                endcase
            end
            ST_SECOND: begin
                // external strobes only in external modes
                if (pendRead) begin
                    next_memReadExternal = pendExt;
                    // reads fill only the read latch
                    next_readLatch = memReadData;
                end else begin
                    // data goes out in second cycle
                    next_memWriteExternal = pendExt;
                end
                next_tablePointer = pmta_bump(tablePointer, pendInc);
                next_pendInc = 1'b0;
                next_state = ST_IDLE;
            end
            ST_LONG: begin
                next_memWriteInternal = 1'b1;
                // only interrupt ends; else await reset
                if (anyActive) begin
                    next_memWriteInternal = 1'b0;
                    // vector only with disable bit clear
                    next_vectorRequest = !globalInterruptDisable;
                    next_coreFlagClear = coreTop;
                    next_tablePointer = pmta_bump(tablePointer, pendInc);
                    next_pendInc = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            writeLatch <= LATCH_RESET;
            readLatch <= LATCH_RESET;
            tablePointer <= PTR_RESET;
            readByte <= 8'h00;
            readByteValid <= 1'b0;
            pendInc <= 1'b0;
            pendRead <= 1'b0;
            pendExt <= 1'b0;
            memAddr <= 16'h0000;
            memWriteData <= 16'h0000;
            memWriteInternal <= 1'b0;
            memWriteExternal <= 1'b0;
            memReadExternal <= 1'b0;
            vectorRequest <= 1'b0;
            coreFlagClear <= '0;
        end else begin
            state <= next_state;
            writeLatch <= next_writeLatch;
            readLatch <= next_readLatch;
            tablePointer <= next_tablePointer;
            readByte <= next_readByte;
            readByteValid <= next_readByteValid;
            pendInc <= next_pendInc;
            pendRead <= next_pendRead;
            pendExt <= next_pendExt;
            memAddr <= next_memAddr;
            memWriteData <= next_memWriteData;
            memWriteInternal <= next_memWriteInternal;
            memWriteExternal <= next_memWriteExternal;
            memReadExternal <= next_memReadExternal;
            vectorRequest <= next_vectorRequest;
            coreFlagClear <= next_coreFlagClear;
        end
    end

    // Checks on the sequence
    AST_EXT_WR_TWO: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_IDLE && opCode == PMTA_OP_TABLE_WR && externalMode)
        |=> (state == ST_SECOND) ##1 (memWriteExternal && state == ST_IDLE))
        else $error("external write not two cycles");
    AST_INC_PTR: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_SECOND && pendInc) |=> tablePointer == $past(tablePointer) + 16'h0001)
        else $error("pointer not incremented");
    AST_NO_INC: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_SECOND && !pendInc) |=> $stable(tablePointer))
        else $error("pointer changed without increment");
    // An interrupt in the first halted cycle may end the write at once
    AST_LONG_START: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_IDLE && opCode == PMTA_OP_TABLE_WR && !externalMode
         && programVoltageOk && !anyActive) |=> halted ##1 (memWriteInternal || !halted))
        else $error("long write not started");
    AST_LONG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (halted && !anyActive) |=> halted)
        else $error("long write ended without interrupt");
    AST_VECTOR: assert property (@(posedge clk) disable iff (!rst_n)
        (halted && anyActive) |=> (!halted && vectorRequest == !$past(globalInterruptDisable)))
        else $error("vectoring wrong on termination");
    AST_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_IDLE && opCode == PMTA_OP_TABLE_WR && !externalMode && anyActive)
        |=> (!halted && coreFlagClear == $past(coreTop)) ##1 !memWriteInternal)
        else $error("pending interrupt did not abort write");
    AST_PERIPH_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
        (halted && !(|coreActive) && anyActive) |=> coreFlagClear == '0)
        else $error("peripheral termination cleared a core flag");
    AST_READ_STALE: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_IDLE && opCode == PMTA_OP_TABLE_RD && opHigh)
        |=> (readByteValid && readByte == $past(readLatch[15:8]))
            ##1 readLatch == $past(memReadData))
        else $error("table read order wrong");
    AST_SEP_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_SECOND && pendRead) |=> $stable(writeLatch))
        else $error("read touched write latch");
endmodule
`default_nettype wire

// file: verification/pmta_prog_mem.sv
// Program memory model facing the table access unit
`timescale 1ns/1ns
`default_nettype none
module pmta_prog_mem (
    input  wire logic        clk,
    input  wire logic [15:0] memAddr,
    input  wire logic [15:0] memWriteData,
    input  wire logic        memWriteInternal,
    input  wire logic        memWriteExternal,
    output logic      [15:0] memReadData
);
    logic [15:0] mem [0:255];
    // Distinct preset words so a stale latch shows
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {8'hc0 ^ i[7:0], i[7:0]};
        end
    end
    always @(posedge clk) begin
        if (memWriteExternal || memWriteInternal) begin
            mem[memAddr[7:0]] <= memWriteData;
        end
    end
    // Only low 256 words exist, upper address bits alias
    assign memReadData = mem[memAddr[7:0]];
endmodule
`default_nettype wire

// file: verification/pmta_table_access_tb.sv
// Self-checking bench for the table access unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin nMismatch++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
`define WAITF(c) begin for (k = 0; k < 40 && !(c); k++) @(negedge clk); \
    if (!(c)) begin nMismatch++; summarize(); end end
module pmta_table_access_tb
    import pmta_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0;
    pmta_op_t    opCode = PMTA_OP_NONE;
    logic        opHigh = 1'b0, opIncrement = 1'b0, ptrLoadHigh = 1'b0, ptrLoadLow = 1'b0;
    logic [7:0]  opData = 8'h00, ptrLoadData = 8'h00, readByte;
    logic        externalMode = 1'b1, programVoltageOk = 1'b1, globalInterruptDisable = 1'b1;
    logic [2:0]  coreIntEnable = 3'h0, coreIntFlag = 3'h0, coreFlagClear, clr;
    logic [3:0]  periphIntEnable = 4'h0, periphIntFlag = 4'h0;
    logic [15:0] memReadData, memAddr, memWriteData, tablePointer;
    logic        readByteValid, busy, halted, memWriteInternal, memWriteExternal;
    logic        memReadExternal, vectorRequest, vec, rdx;
    int          nMismatch = 0, nCompared = 0, k;
    // Instruction clock, 4 ns
    always #2 clk = ~clk;
    pmta_table_access dut_u (.clk, .rst_n, .opCode, .opHigh, .opIncrement, .opData,
        .ptrLoadHigh, .ptrLoadLow, .ptrLoadData, .externalMode, .programVoltageOk,
        .globalInterruptDisable, .coreIntEnable, .coreIntFlag, .periphIntEnable,
        .periphIntFlag, .memReadData, .readByte, .readByteValid, .busy, .halted,
        .memAddr, .memWriteData, .memWriteInternal, .memWriteExternal,
        .memReadExternal, .vectorRequest, .coreFlagClear, .tablePointer);
    pmta_prog_mem mem_u (.clk, .memAddr, .memWriteData, .memWriteInternal,
        .memWriteExternal, .memReadData);
    task automatic summarize();
        if (nMismatch == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One operation, ends at the negedge after it is taken
    task automatic op(pmta_op_t c, logic h, logic i, logic [7:0] d);
        `WAITF(!busy)
        @(negedge clk);
        opCode = c;
        opHigh = h;
        opIncrement = i;
        opData = d;
        @(negedge clk);
        opCode = PMTA_OP_NONE;
    endtask
    // Pointer bytes go in one at a time, the unit has one byte lane
    task automatic setptr(logic [15:0] v);
        @(negedge clk);
        ptrLoadHigh = 1'b1;
        ptrLoadData = v[15:8];
        @(negedge clk);
        ptrLoadHigh = 1'b0;
        ptrLoadLow = 1'b1;
        ptrLoadData = v[7:0];
        @(negedge clk);
        ptrLoadLow = 1'b0;
    endtask
    // External write, then read back through the separate read latch
    task automatic ext_write_read();
        setptr(16'h0010);
        op(PMTA_OP_LATCH_WR, 1'b1, 1'b0, 8'ha5);
        op(PMTA_OP_TABLE_WR, 1'b0, 1'b1, 8'h3c);
        `CHK("busy", 1'b1, busy)
        `CHK("addr", 16'h0010, memAddr)
        `CHK("wdata", 16'ha53c, memWriteData)
        @(negedge clk);
        `CHK("extwr", 1'b1, memWriteExternal)
        `CHK("busy2", 1'b0, busy)
        `CHK("ptr", 16'h0011, tablePointer)
        setptr(16'h0010);
        op(PMTA_OP_TABLE_RD, 1'b1, 1'b0, 8'h00);
        `CHK("stale", 8'h00, readByte)
        @(negedge clk);
        `CHK("extrd", 1'b1, memReadExternal)
        op(PMTA_OP_LATCH_RD, 1'b1, 1'b0, 8'h00);
        `CHK("rdhi", 8'ha5, readByte)
        `CHK("rdv", 1'b1, readByteValid)
        op(PMTA_OP_LATCH_RD, 1'b0, 1'b0, 8'h00);
        `CHK("rdlo", 8'h3c, readByte)
        `CHK("rdptr", 16'h0010, tablePointer)
    endtask
    // Internal write without programming voltage stays short
    task automatic no_vpp();
        programVoltageOk = 1'b0;
        op(PMTA_OP_TABLE_WR, 1'b0, 1'b0, 8'h01);
        `CHK("nvbusy", 1'b1, busy)
        `CHK("nvhalt", 1'b0, halted)
        @(negedge clk);
        `CHK("nvdone", 1'b0, busy)
        `CHK("nvwr", 1'b0, memWriteInternal)
        `CHK("nvmem", 16'ha53c, mem_u.mem[16])
        programVoltageOk = 1'b1;
    endtask
    // Long write: flags of disabled sources first, then all flags
    task automatic run_long(logic g, logic [2:0] ce, logic [3:0] pe, logic [2:0] eclr,
                            logic ev);
        globalInterruptDisable = g;
        coreIntEnable = ce;
        periphIntEnable = pe;
        coreIntFlag = ~ce;
        periphIntFlag = ~pe;
        op(PMTA_OP_TABLE_WR, 1'b1, 1'b1, 8'h77);
        repeat (4) @(negedge clk);
        `CHK("halt", 1'b1, halted)
        `CHK("wrint", 1'b1, memWriteInternal)
        clr = 3'h0;
        vec = 1'b0;
        coreIntFlag = 3'h7;
        periphIntFlag = 4'hf;
        for (k = 0; k < 4; k++) begin
            @(negedge clk);
            clr |= coreFlagClear;
            vec |= vectorRequest;
        end
        `CHK("halt2", 1'b0, halted)
        `CHK("clr", eclr, clr)
        `CHK("vec", ev, vec)
        coreIntFlag = 3'h0;
        periphIntFlag = 4'h0;
    endtask
    // Write issued with an enabled flag already pending
    task automatic abort_pending();
        coreIntEnable = 3'h3;
        coreIntFlag = 3'h3;
        setptr(16'h0040);
        clr = 3'h0;
        op(PMTA_OP_TABLE_WR, 1'b0, 1'b1, 8'h02);
        for (k = 0; k < 3; k++) begin
            clr |= coreFlagClear;
            `CHK("abhalt", 1'b0, halted)
            @(negedge clk);
        end
        `CHK("abclr", 3'h1, clr)
        `CHK("abptr", 16'h0040, tablePointer)
        coreIntFlag = 3'h0;
        coreIntEnable = 3'h0;
    endtask
    // Unterminated long write ends only by reset; pointer wraps
    task automatic reset_and_wrap();
        op(PMTA_OP_TABLE_WR, 1'b0, 1'b0, 8'h03);
        repeat (20) @(negedge clk);
        `CHK("rhalt", 1'b1, halted)
        rst_n = 1'b0;
        @(negedge clk);
        `CHK("rclr", 1'b0, halted)
        rst_n = 1'b1;
        setptr(16'hffff);
        rdx = 1'b0;
        op(PMTA_OP_TABLE_RD, 1'b0, 1'b1, 8'h00);
        repeat (2) begin
            rdx |= memReadExternal;
            @(negedge clk);
        end
        `CHK("wrap", 16'h0000, tablePointer)
        `CHK("intrd", 1'b0, rdx)
    endtask
    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        ext_write_read();
        externalMode = 1'b0;
        no_vpp();
        run_long(1'b1, 3'h2, 4'h0, 3'h2, 1'b0);
        run_long(1'b0, 3'h0, 4'h4, 3'h0, 1'b1);
        abort_pending();
        reset_and_wrap();
        summarize();
    end
endmodule
`default_nettype wire
